// [design/status_readback_defines.svh]
`ifndef STATUS_READBACK_DEFINES_SVH
`define STATUS_READBACK_DEFINES_SVH

// register addresses on the serial link
`define ADDR_SUMMARY_STATUS 5'h16
`define ADDR_SILICON_REVISION 5'h17
`define ADDR_OSC_TICK_COUNT 5'h18

// readback word layout
`define WORD_W 22
`define FAULT_BIT 21
`define ADDR_HI 20
`define ADDR_LO 16
`define DIG_SUM_BIT 20
`define ANA_SUM_BIT 19
`define WDT_BIT 18
`define BUSY_BIT 17
`define CH_HI 16
`define CH_LO 12
`define DATA_HI 11
`define DATA_LO 0
`define REG_REV_HI 10
`define REG_REV_LO 8
`define MAIN_REV_HI 7
`define MAIN_REV_LO 0
`define CNT_HI 15
`define CNT_LO 0

// digital diagnostic flag vector
`define DIG_FLAGS_W 16
`define DIG_SLEW_BIT 10
`define DIG_RESET_SEEN_BIT 15
`define DIG_QUIET_MASK 16'hfff8
`define DIG_ALL_MASK 16'hffff

// analog diagnostic flag vector
`define ANA_FLAGS_W 14

// reset values
`define SUMMARY_STATUS_RESET 22'h100000
`define OSC_TICK_COUNT_RESET 22'h180000
`define WORD_RESET 22'h000000
`define TICK_CNT_RESET 16'h0000
`define TICK_CNT_MAX 16'hffff

// master clock divide ratio for the 1 kHz tick
`define TICK_DIV 10000

`endif

// [design/status_readback_pkg.sv]
package status_readback_pkg;

   typedef struct packed {
      logic rd_valid;
      logic [21:0] rd_data;
      logic [13:0] ana_flags;
      logic reset_seen;
      logic [15:0] tick_cnt;
      logic sum_dig;
      logic sum_ana;
   } readback_state_s;

   typedef struct packed {
      logic [13:0] cnt;
      logic tick;
   } divider_state_s;

endpackage

// [design/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_divider
   import status_readback_pkg::*;
#(
   parameter int DIV = 10000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // one-cycle pulse every DIV clocks
   output logic tick
);
   localparam logic [13:0] LAST = 14'(DIV - 1);

   divider_state_s q, d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == LAST) begin
         d.cnt = 14'h0000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 14'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule
`default_nettype wire

// [design/status_readback.sv]
// How it works
// - bit 21 shows inverted fault pin
// - digital summary ORs flags, slewing excluded
// - reset seen flag sets summary after reset
// - quiet mode ORs only bits 15..11 and 9..3
// - in quiet mode link errors alone never raise digital summary
// - analog summary ORs analog flags 13..0
// - channel, busy and watchdog bits placed
// - low twelve bits carry conversion result
// - revision and tick words echo address
// - revision word carries both die revisions
// - master clock divided by ten thousand
// - tick count readable in low sixteen bits
// - tick counter runs under enable bit
// - analog flags clear only on write-one or reset
// - summary at 0x16, reset word 0x100000
`timescale 1ns/1ps
`default_nettype none
`include "status_readback_defines.svh"
module status_readback
   import status_readback_pkg::*;
#(
   parameter int TICK_DIV = `TICK_DIV,
   // arbitrary neutral revision values
   parameter logic [2:0] REG_DIE_REV = 3'h5,
   parameter logic [7:0] MAIN_DIE_REV = 8'h5a
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register read port from the serial front end
   input wire logic rd_req,
   input wire logic [4:0] rd_addr,
   output logic rd_valid,
   output logic [21:0] rd_data,
   // fault pin level as driven
   input wire logic fault_pin_level,
   // digital diagnostics and configuration
   input wire logic [15:0] digital_diag_flag_reg,
   input wire logic reset_seen_clr,
   input wire logic link_diag_quiet_enable,
   input wire logic tick_counter_enable,
   // analog diagnostic events and host write-one clear
   input wire logic [13:0] ana_event,
   input wire logic ana_clr_wr,
   input wire logic [13:0] ana_clr_data,
   // converter and watchdog status
   input wire logic watchdog_flag,
   input wire logic converter_busy,
   input wire logic [4:0] converter_channel,
   input wire logic [11:0] converter_result,
   // live summaries
   output logic digital_diag_summary,
   output logic analog_diag_summary
);

   readback_state_s q, d;
   logic tick;
   logic [15:0] dig_vec;
   logic [15:0] dig_mask;
   logic dig_sum;
   logic ana_sum;
   logic [21:0] word_status;
   logic [21:0] word_rev;
   logic [21:0] word_cnt;
   logic [21:0] word_other;

   tick_divider #(
      .DIV(TICK_DIV)
   ) u_tick_divider (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   always_comb begin
      dig_vec = digital_diag_flag_reg;
      dig_vec[`DIG_RESET_SEEN_BIT] = digital_diag_flag_reg[`DIG_RESET_SEEN_BIT] | q.reset_seen;
   end

   always_comb begin
      if (link_diag_quiet_enable) begin
         dig_mask = `DIG_QUIET_MASK;
      end else begin
         dig_mask = `DIG_ALL_MASK;
      end
      dig_mask[`DIG_SLEW_BIT] = 1'b0;
   end

   always_comb begin
      dig_sum = |(dig_vec & dig_mask);
      ana_sum = |q.ana_flags;
   end

   always_comb begin
      word_status = `WORD_RESET;
      word_status[`FAULT_BIT] = ~fault_pin_level;
      word_status[`DIG_SUM_BIT] = dig_sum;
      word_status[`ANA_SUM_BIT] = ana_sum;
      word_status[`WDT_BIT] = watchdog_flag;
      word_status[`BUSY_BIT] = converter_busy;
      word_status[`CH_HI:`CH_LO] = converter_channel;
      word_status[`DATA_HI:`DATA_LO] = converter_result;
   end

   always_comb begin
      word_rev = `WORD_RESET;
      word_rev[`FAULT_BIT] = ~fault_pin_level;
      word_rev[`ADDR_HI:`ADDR_LO] = `ADDR_SILICON_REVISION;
      word_rev[`REG_REV_HI:`REG_REV_LO] = REG_DIE_REV;
      word_rev[`MAIN_REV_HI:`MAIN_REV_LO] = MAIN_DIE_REV;
   end

   always_comb begin
      word_cnt = `WORD_RESET;
      word_cnt[`FAULT_BIT] = ~fault_pin_level;
      word_cnt[`ADDR_HI:`ADDR_LO] = `ADDR_OSC_TICK_COUNT;
      word_cnt[`CNT_HI:`CNT_LO] = q.tick_cnt;
   end

   always_comb begin
      // unmapped addresses echo the address with empty data
      word_other = `WORD_RESET;
      word_other[`FAULT_BIT] = ~fault_pin_level;
      word_other[`ADDR_HI:`ADDR_LO] = rd_addr;
   end

   always_comb begin
      d = q;
      d.rd_valid = 1'b0;
      if (rd_req) begin
         d.rd_valid = 1'b1;
         case (rd_addr)
            `ADDR_SUMMARY_STATUS: begin
               d.rd_data = word_status;
            end
            `ADDR_SILICON_REVISION: begin
               d.rd_data = word_rev;
            end
            `ADDR_OSC_TICK_COUNT: begin
               d.rd_data = word_cnt;
            end
            default: begin
               d.rd_data = word_other;
            end
         endcase
      end

      // clear only by host, reset sets it
      if (reset_seen_clr) begin
         d.reset_seen = 1'b0;
      end

      if (ana_clr_wr) begin
         d.ana_flags = q.ana_flags & ~ana_clr_data;
      end
      d.ana_flags = d.ana_flags | ana_event;

      if (tick && tick_counter_enable) begin
         if (q.tick_cnt == `TICK_CNT_MAX) begin
            d.tick_cnt = `TICK_CNT_RESET;
         end else begin
            d.tick_cnt = q.tick_cnt + 16'h0001;
         end
      end

      // registered summaries keep every output on a flop
      d.sum_dig = dig_sum;
      d.sum_ana = ana_sum;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q.rd_valid <= 1'b0;
         q.rd_data <= `WORD_RESET;
         q.ana_flags <= '0;
         q.reset_seen <= 1'b1;
         q.tick_cnt <= `TICK_CNT_RESET;
         q.sum_dig <= 1'b1;
         q.sum_ana <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign rd_valid = q.rd_valid;
   assign rd_data = q.rd_data;
   assign digital_diag_summary = q.sum_dig;
   assign analog_diag_summary = q.sum_ana;

endmodule
`default_nettype wire

// [bench/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic sys_clk,
   // command from bench
   input wire logic go,
   input wire logic [4:0] a,
   // read port
   output logic rd_req = 1'b0,
   output logic [4:0] rd_addr = 5'h0
);
   // polled reads
   // idle address is inverted so a stale value is never mistaken for live
   always_ff @(posedge sys_clk) begin
      rd_req <= go;
      rd_addr <= go ? a : ~rd_addr;
   end
endmodule
`default_nettype wire

// [bench/readback_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module readback_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // read port
   input wire logic rd_req,
   input wire logic [4:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [21:0] rd_data,
   // sources and summaries
   input wire logic fault_pin_level,
   input wire logic [15:0] digital_diag_flag_reg,
   input wire logic [13:0] ana_event,
   input wire logic digital_diag_summary,
   input wire logic analog_diag_summary
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   valid_lat_a: assert property (
      rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req))) else $error("late answer");
   hold_a: assert property (
      !rd_req |=> $stable(rd_data)) else $error("word moved");
   fault_bit_a: assert property (
      rd_req |=> rd_data[21] == !$past(fault_pin_level)) else $error("fault bit");
   sum_copy_a: assert property (
      rd_req && rd_addr == 5'h16 |=> rd_data[20:19] == {digital_diag_summary, analog_diag_summary})
      else $error("summary bits");
   addr_echo_a: assert property (
      rd_req && rd_addr inside {5'h17, 5'h18} |=> rd_data[20:16] == $past(rd_addr)) else $error("echo");
   rev_resvd_a: assert property (
      rd_req && rd_addr == 5'h17 |=> rd_data[15:11] == 5'h0) else $error("reserved bits");
   dig_sum_a: assert property (
      (digital_diag_flag_reg & 16'h7bf8) != 16'h0 |=> digital_diag_summary) else $error("dig summary");
   ana_sum_a: assert property (
      ana_event != 14'h0 |=> ##1 analog_diag_summary) else $error("ana summary");
   cover property (rd_req && rd_addr == 5'h18);
   cover property (rd_req && rd_addr == 5'h17);
   cover property ($rose(analog_diag_summary));
endmodule
bind status_readback readback_sva i_sva (.sys_clk, .rst_n, .rd_req, .rd_addr, .rd_valid, .rd_data,
   .fault_pin_level, .digital_diag_flag_reg, .ana_event, .digital_diag_summary, .analog_diag_summary);
`default_nettype wire

// [bench/test_status_readback.sv]
`timescale 1ns/1ps
`default_nettype none
module test_status_readback;
   typedef struct packed {
      logic [4:0] a;
      logic f;
      logic [15:0] dg;
      logic q;
      logic [18:0] st;
      logic [21:0] e;
   } row_s;
   logic sys_clk, rd_req, rd_valid, dsum, asum;
   logic rst_n = 1'b0, go = 1'b0, clr = 1'b0, quiet = 1'b0, ana_wr = 1'b0;
   logic fault_pin_level = 1'b1, en = 1'b1;
   logic [4:0] a = 5'h0, rd_addr;
   logic [15:0] dg = 16'h0;
   logic [18:0] st = 19'h0;
   logic [13:0] ev = 14'h0, cd = 14'h0;
   logic [21:0] rd_data, d, d0;
   int fails = 0, checked = 0;
   row_s rows [9];
   status_readback #(.TICK_DIV(10), .REG_DIE_REV(3'h5), .MAIN_DIE_REV(8'h5a)) i_dut (.sys_clk, .rst_n,
      .rd_req, .rd_addr, .rd_valid, .rd_data,
      .fault_pin_level, .digital_diag_flag_reg(dg), .reset_seen_clr(clr), .link_diag_quiet_enable(quiet),
      .tick_counter_enable(en), .ana_event(ev), .ana_clr_wr(ana_wr), .ana_clr_data(cd),
      .watchdog_flag(st[18]), .converter_busy(st[17]), .converter_channel(st[16:12]),
      .converter_result(st[11:0]), .digital_diag_summary(dsum), .analog_diag_summary(asum));
   host_model i_host (.sys_clk, .go, .a, .rd_req, .rd_addr);
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic ck(input logic [21:0] g, input logic [21:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("Error %0t: read %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [4:0] ad, output logic [21:0] q);
      go <= 1'b1;
      a <= ad;
      @(posedge sys_clk);
      go <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1) begin
            q = rd_data;
            return;
         end
      end
      fails++;
      tally_and_finish();
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      rows = '{'{5'h16, 1'b1, 16'h0, 1'b0, 19'h0, 22'h000000},
         '{5'h16, 1'b0, 16'h0, 1'b0, 19'h5fabc, 22'h25fabc},
         '{5'h16, 1'b1, 16'h0, 1'b0, 19'h20000, 22'h020000},
         '{5'h16, 1'b1, 16'h0400, 1'b0, 19'h0, 22'h000000},
         '{5'h16, 1'b1, 16'h0001, 1'b0, 19'h0, 22'h100000},
         '{5'h16, 1'b1, 16'h0007, 1'b1, 19'h0, 22'h000000},
         '{5'h16, 1'b1, 16'h0008, 1'b1, 19'h0, 22'h100000},
         '{5'h17, 1'b1, 16'h0, 1'b0, 19'h0, 22'h17055a},
         '{5'h1f, 1'b0, 16'h0, 1'b0, 19'h0, 22'h3f0000}};
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      foreach (rows[k]) begin
         fault_pin_level <= rows[k].f;
         dg <= rows[k].dg;
         quiet <= rows[k].q;
         st <= rows[k].st;
         rd(rows[k].a, d);
         ck(d, rows[k].e);
         if (rows[k].a == 5'h16) begin
            ck({21'h0, dsum}, {21'h0, rows[k].e[20]});
         end
      end
      // reads 100 cycles apart see ten ticks, then none once the enable is cleared
      fault_pin_level <= 1'b1;
      rd(5'h18, d0);
      repeat (97) @(posedge sys_clk);
      rd(5'h18, d);
      ck(d, d0 + 22'd10);
      en <= 1'b0;
      @(posedge sys_clk);
      rd(5'h18, d0);
      repeat (97) @(posedge sys_clk);
      rd(5'h18, d);
      ck(d, d0);
      // sticky flag, set beats clear
      ev <= 14'h2000;
      @(posedge sys_clk);
      ev <= 14'h0;
      ana_wr <= 1'b1;
      rd(5'h16, d);
      ck(d & 22'h080000, 22'h080000);
      ck({21'h0, asum}, 22'h000001);
      ev <= 14'h2000;
      cd <= 14'h2000;
      @(posedge sys_clk);
      ev <= 14'h0;
      ana_wr <= 1'b0;
      rd(5'h16, d);
      ck(d & 22'h080000, 22'h080000);
      ck({21'h0, asum}, 22'h000001);
      ana_wr <= 1'b1;
      @(posedge sys_clk);
      ana_wr <= 1'b0;
      rd(5'h16, d);
      ck(d & 22'h080000, 22'h000000);
      ck({21'h0, asum}, 22'h000000);
      // second reset mid-run
      rst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(5'h18, d);
      ck(d, 22'h180000);
      rd(5'h16, d);
      ck(d, 22'h100000);
      ck({20'h0, dsum, asum}, 22'h000002);
      tally_and_finish();
   end
endmodule
`default_nettype wire
